// ===== core/adsc_clk_div.sv
`timescale 1ns/10ps
`include "adsc_consts.svh"
// converter clock enable from the core clock
module adsc_clk_div
  import adsc_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       restart_in,
  input  wire logic [2:0] divide_sel_in,
  output logic            tick_out
);
  import adsc_pkg::*;

  logic [9:0] count_q;
  logic [9:0] limit;

  // divide by 8 * (code + 1)
  assign limit = 10'(`ADSC_DIV_STEP * ({7'h00, divide_sel_in} + 10'h001))
               - 10'h001;

  // -------------------------------------------------------
  // divider counter
  // -------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      count_q  <= 10'h000;
      tick_out <= 1'b0;
    end
    else if (restart_in)
    begin
      count_q  <= 10'h000;
      tick_out <= 1'b0;
    end
    else if (count_q >= limit)
    begin
      count_q  <= 10'h000;
      tick_out <= 1'b1;
    end
    else
    begin
      count_q  <= count_q + 10'h001;
      tick_out <= 1'b0;
    end
  end
endmodule // adsc_clk_div

// ===== core/adsc_consts.svh
`ifndef ADSC_CONSTS_SVH
`define ADSC_CONSTS_SVH
// control register field positions
`define ADSC_CTL_ENABLE_BIT    15
`define ADSC_CTL_DONE_BIT      12
`define ADSC_CTL_TIMING_BIT    11
`define ADSC_CTL_IRQEN_BIT     10
`define ADSC_CTL_START_HI      9
`define ADSC_CTL_START_LO      8
`define ADSC_CTL_DIV_HI        7
`define ADSC_CTL_DIV_LO        5
`define ADSC_CTL_QUAD_BIT      4
`define ADSC_CTL_SCAN_BIT      3
`define ADSC_CTL_CHAN_HI       1
`define ADSC_CTL_CHAN_LO       0
// reset value of the control register
`define ADSC_CTL_RESET         16'h0000
// divider step: converter clock is core clock / (step * (code + 1))
`define ADSC_DIV_STEP          7'h08
// converter clock cycles for one conversion (auto-zero plus sampling)
`define ADSC_AZ_CYCLES         4'h1
`define ADSC_CONV_CYCLES       4'ha
// completed conversions before the done flag when timing bit is set
`define ADSC_LATE_IRQ_COUNT    3'h4
`endif

// ===== core/adsc_control.sv
`timescale 1ns/10ps
`include "adsc_consts.svh"
module adsc_control
  import adsc_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        resetn_in,
  // control register port
  input  wire logic        ctl_wr_in,
  input  wire logic [15:0] ctl_wdata_in,
  output logic      [15:0] ctl_rdata_out,
  input  wire logic [1:0]  result_sel_in,
  output logic      [7:0]  result_rdata_out,
  // start sources, same-clock pulses
  input  wire logic        ext_irq_1_in,
  input  wire logic        timer_2_in,
  input  wire logic        timer_0_in,
  // analogue converter
  output logic             conv_autozero_out,
  output logic             conv_sample_out,
  output logic      [1:0]  conv_channel_out,
  input  wire logic [7:0]  conv_data_in,
  output logic             irq_out
);
  import adsc_pkg::*;

  logic [15:0]     ctl_q;
  logic            done_q;
  adsc_state_t     state_q;
  logic [1:0]      chan_q;
  logic [1:0]      step_q;
  logic [3:0]      cyc_q;
  logic [2:0]      done_cnt_q;
  logic [7:0]      result_q [4];
  logic            enable;
  logic            trigger;
  logic            tick;
  logic            conv_end;
  logic            quad;
  logic            scan;
  logic            last;
  logic [1:0]      dest;
  adsc_src_t       src;

  assign enable = ctl_q[`ADSC_CTL_ENABLE_BIT];
  assign quad   = ctl_q[`ADSC_CTL_QUAD_BIT];
  assign scan   = ctl_q[`ADSC_CTL_SCAN_BIT];
  assign src    = adsc_src_t'(ctl_q[`ADSC_CTL_START_HI:`ADSC_CTL_START_LO]);

  // -------------------------------------------------------
  // start trigger selection
  // -------------------------------------------------------
  always_comb
  begin
    unique case (src)
      ADSC_SRC_WRITE:  trigger = ctl_wr_in
                                 & ctl_wdata_in[`ADSC_CTL_ENABLE_BIT];
      ADSC_SRC_EXT1:   trigger = ext_irq_1_in;
      ADSC_SRC_TIMER2: trigger = timer_2_in;
      ADSC_SRC_TIMER0: trigger = timer_0_in;
    endcase
    if (!enable && !(ctl_wr_in && src == ADSC_SRC_WRITE))
      trigger = 1'b0;
  end

  // -------------------------------------------------------
  // converter clock enable
  // -------------------------------------------------------
  adsc_clk_div u_div (
    .core_clk_in   (core_clk_in),
    .resetn_in     (resetn_in),
    .restart_in    (trigger),
    .divide_sel_in (ctl_q[`ADSC_CTL_DIV_HI:`ADSC_CTL_DIV_LO]),
    .tick_out      (tick)
  );

  assign conv_end = (state_q == ADSC_CONV) && tick
                    && (cyc_q == `ADSC_CONV_CYCLES - 4'h1);
  // sequence ends after one, or four conversions; never in continuous
  assign last = (quad && scan) ? 1'b0 :
                (!quad && scan) ? 1'b1 : (step_q == 2'h3);
  assign dest = (!quad && !scan) ? step_q : chan_q;

  // -------------------------------------------------------
  // control register
  // -------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ctl_q <= `ADSC_CTL_RESET;
    else if (ctl_wr_in && enable)
      ctl_q <= ctl_wdata_in & 16'h8fff;
    else if (ctl_wr_in)
      ctl_q[`ADSC_CTL_ENABLE_BIT] <= ctl_wdata_in[`ADSC_CTL_ENABLE_BIT];
  end

  // -------------------------------------------------------
  // conversion sequencer
  // -------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= ADSC_IDLE;
      chan_q  <= 2'h0;
      step_q  <= 2'h0;
      cyc_q   <= 4'h0;
    end
    else if (ctl_wr_in && !ctl_wdata_in[`ADSC_CTL_ENABLE_BIT])
    begin
      state_q <= ADSC_IDLE;
      cyc_q   <= 4'h0;
    end
    else if (trigger)
    begin
      // abort any running conversion and restart
      state_q <= ADSC_ZERO;
      chan_q  <= ctl_wr_in ?
                 ctl_wdata_in[`ADSC_CTL_CHAN_HI:`ADSC_CTL_CHAN_LO] :
                 ctl_q[`ADSC_CTL_CHAN_HI:`ADSC_CTL_CHAN_LO];
      step_q  <= 2'h0;
      cyc_q   <= 4'h0;
    end
    else if (tick)
    begin
      unique case (state_q)
        ADSC_IDLE: cyc_q <= 4'h0;
        ADSC_ZERO:
        begin
          if (cyc_q == `ADSC_AZ_CYCLES - 4'h1)
          begin
            state_q <= ADSC_CONV;
            cyc_q   <= 4'h0;
          end
          else
            cyc_q <= cyc_q + 4'h1;
        end
        ADSC_CONV:
        begin
          if (conv_end)
          begin
            cyc_q   <= 4'h0;
            step_q  <= step_q + 2'h1;
            state_q <= last ? ADSC_IDLE : ADSC_ZERO;
            if (quad)
              chan_q <= chan_q + 2'h1;
          end
          else
            cyc_q <= cyc_q + 4'h1;
        end
        default: state_q <= ADSC_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------
  // result registers
  // -------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      for (int i = 0; i < 4; i++)
        result_q[i] <= 8'h00;
    end
    else if (conv_end && !trigger)
      result_q[dest] <= conv_data_in;
  end

  // -------------------------------------------------------
  // done flag and interrupt
  // -------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      done_q     <= 1'b0;
      done_cnt_q <= 3'h0;
    end
    else if (conv_end && !trigger && ctl_q[`ADSC_CTL_IRQEN_BIT])
    begin
      // a completion in the write cycle still sets the flag
      if (!ctl_q[`ADSC_CTL_TIMING_BIT]
          || done_cnt_q == `ADSC_LATE_IRQ_COUNT - 3'h1)
      begin
        done_q     <= 1'b1;
        done_cnt_q <= 3'h0;
      end
      else
      begin
        done_cnt_q <= done_cnt_q + 3'h1;
        if (ctl_wr_in)
          done_q <= 1'b0;
      end
    end
    else if (ctl_wr_in)
    begin
      done_q     <= 1'b0;
      done_cnt_q <= 3'h0;
    end
  end

  // -------------------------------------------------------
  // outputs
  // -------------------------------------------------------
  always_comb
  begin
    ctl_rdata_out = ctl_q;
    ctl_rdata_out[`ADSC_CTL_DONE_BIT] = done_q;
    result_rdata_out = enable ? result_q[result_sel_in] : 8'h00;
  end

  assign irq_out           = done_q;
  assign conv_autozero_out = (state_q == ADSC_ZERO);
  assign conv_sample_out   = (state_q == ADSC_CONV);
  assign conv_channel_out  = chan_q;
endmodule // adsc_control

// ===== core/adsc_pkg.sv
package adsc_pkg;
  typedef enum logic [2:0] {
    ADSC_IDLE = 3'b001,
    ADSC_ZERO = 3'b010,
    ADSC_CONV = 3'b100
  } adsc_state_t;
  typedef enum logic [1:0] {
    ADSC_SRC_WRITE  = 2'h0,
    ADSC_SRC_EXT1   = 2'h1,
    ADSC_SRC_TIMER2 = 2'h2,
    ADSC_SRC_TIMER0 = 2'h3
  } adsc_src_t;
endpackage

// ===== tb/adc_sequence_control_bench.sv
`timescale 1ns/10ps
// ----------------------------------------
// sequencer bench
// ----------------------------------------
module adc_sequence_control_bench;
  import adsc_pkg::*;
  typedef struct {logic [15:0] w; logic [31:0] r;} adsc_row_t;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wr = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [1:0]  sel = 2'h0;
  logic        e1 = 1'b0;
  logic        t2 = 1'b0;
  logic        t0 = 1'b0;
  logic [15:0] rd;
  logic [7:0]  res;
  logic [7:0]  din;
  logic [1:0]  ch;
  logic        az;
  logic        smp;
  logic        irq;
  int          num_errors = 0;
  int          n_tests = 0;
  adsc_row_t   rows [5] = '{'{16'h842a, 32'h00a2_0000},
    '{16'h8c03, 32'ha3a3_a3a3}, '{16'h8c11, 32'ha3a2_a1a0},
    '{16'h8cfa, 32'ha3a2_a1a0}, '{16'h8453, 32'ha300_0000}};
  // clock
  always #4 clk = ~clk;
  adsc_control adsc_control_inst (.core_clk_in(clk), .resetn_in(rst_n),
    .ctl_wr_in(wr), .ctl_wdata_in(wd), .ctl_rdata_out(rd),
    .result_sel_in(sel), .result_rdata_out(res), .ext_irq_1_in(e1),
    .timer_2_in(t2), .timer_0_in(t0), .conv_autozero_out(az),
    .conv_sample_out(smp), .conv_channel_out(ch), .conv_data_in(din),
    .irq_out(irq));
  adsc_conv_model adsc_conv_model_inst (.core_clk_in(clk),
    .resetn_in(rst_n), .sample_in(smp), .channel_in(ch), .data_out(din));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [15:0] d);
    wr = 1'b1;
    wd = d;
    cyc(1);
    wr = 1'b0;
  endtask
  // enable, park with enable low, then write the whole word
  task automatic setup(input logic [15:0] d);
    wr = 1'b1;
    wd = 16'h8000;
    cyc(1);
    wd = d & 16'h7fff;
    cyc(1);
    wd = d;
    cyc(1);
    wr = 1'b0;
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
  endtask
  task automatic wait_irq();
    for (int k = 0; k < 4000 && irq !== 1'b1; k++)
      cyc(1);
    check(irq, 1);
    cyc(2);
  endtask
  task automatic res_chk(input logic [31:0] exp);
    for (int s = 0; s < 4; s++)
    begin
      sel = 2'(s);
      cyc(1);
      check(res, exp[8*s+:8]);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog
  initial
  begin
    cyc(40000);
    num_errors++;
    final_report();
  end
  // main sequence
  initial
  begin
    foreach (rows[i])
    begin
      do_reset();
      setup(rows[i].w);
      wait_irq();
      check(rd, rows[i].w | 16'h1000);
      check(adsc_conv_model_inst.n_done, rows[i].w[11] ? 4 : 1);
      check(adsc_conv_model_inst.len, 80 * (rows[i].w[7:5] + 1));
      res_chk(rows[i].r);
    end
    do_reset();
    put(16'h0c43);
    cyc(60);
    check(rd, 0);
    check({az, smp}, 2'h0);
    put(16'h8401);
    cyc(40);
    check(smp, 1);
    check(ch, 1);
    put(16'h8403);
    check(az, 1);
    check(ch, 3);
    wait_irq();
    res_chk(32'h0000_00a3);
    cyc(50);
    check(irq, 1);
    put(16'h8002);
    check(irq, 0);
    cyc(200);
    check(rd, 16'h8002);
    check(irq, 0);
    res_chk(32'h0000_a2a2);
    for (int s = 1; s < 4; s++)
    begin
      do_reset();
      setup(16'h8408 | 16'(s << 8) | 16'(s));
      {t0, t2, e1} = 3'h7 & ~(3'h1 << (s - 1));
      cyc(1);
      {t0, t2, e1} = 3'h0;
      cyc(30);
      check({az, smp}, 2'h0);
      {t0, t2, e1} = 3'h1 << (s - 1);
      cyc(1);
      {t0, t2, e1} = 3'h0;
      wait_irq();
      res_chk({24'h0, 8'ha0 | 8'(s)} << (8 * s));
    end
    final_report();
  end
endmodule // adc_sequence_control_bench

// ===== tb/adsc_control_props.sv
`timescale 1ns/10ps
// ----------------------------------------
// sequencer checker
// ----------------------------------------
module adsc_control_props
  import adsc_pkg::*;
(
  input wire logic        core_clk_in,
  input wire logic        resetn_in,
  input wire logic        ctl_wr_in,
  input wire logic [15:0] ctl_wdata_in,
  input wire logic [15:0] ctl_rdata_out,
  input wire logic [1:0]  result_sel_in,
  input wire logic [7:0]  result_rdata_out,
  input wire logic        ext_irq_1_in,
  input wire logic        timer_2_in,
  input wire logic        timer_0_in,
  input wire logic        conv_autozero_out,
  input wire logic        conv_sample_out,
  input wire logic [1:0]  conv_channel_out,
  input wire logic [7:0]  conv_data_in,
  input wire logic        irq_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  // auto-zero handing over to sampling
  sequence s_az_to_smp;
    conv_autozero_out ##1 conv_sample_out;
  endsequence
  // converter held off for two samples
  sequence s_off;
    !ctl_rdata_out[15] [*2];
  endsequence
  // no write and no start pulse for eight cycles
  sequence s_quiet;
    (!ctl_wr_in && !ext_irq_1_in && !timer_2_in && !timer_0_in) [*8];
  endsequence
  chk_az_first: assert property
    ($rose(conv_sample_out) |-> $past(conv_autozero_out))
    else $error("sampling without auto-zero");
  chk_phase_apart: assert property
    (!(conv_autozero_out && conv_sample_out))
    else $error("phases overlap");
  chk_smp_min: assert property
    (s_az_to_smp ##0 s_quiet |-> conv_sample_out)
    else $error("sampling shorter than one tick");
  chk_chan_order: assert property
    ($fell(conv_sample_out) && conv_autozero_out && ctl_rdata_out[4]
     && !$past(ctl_wr_in || ext_irq_1_in || timer_2_in || timer_0_in)
     |-> conv_channel_out == 2'($past(conv_channel_out) + 2'h1))
    else $error("channel order broken");
  chk_chan_steady: assert property
    (conv_sample_out && $past(conv_sample_out || conv_autozero_out)
     |-> $stable(conv_channel_out))
    else $error("channel moved mid conversion");
  chk_done_clear: assert property
    (ctl_wr_in && !conv_sample_out |=> !irq_out && !ctl_rdata_out[12])
    else $error("done flag survived a write");
  chk_irq_hold: assert property
    (irq_out && !ctl_wr_in |=> irq_out)
    else $error("irq dropped without a write");
  chk_irq_gate: assert property
    ($rose(irq_out) |-> $past(ctl_rdata_out[10]))
    else $error("irq raised while disabled");
  chk_off_idle: assert property
    (s_off |-> !conv_autozero_out && !conv_sample_out)
    else $error("conversion while disabled");
  chk_off_zero: assert property
    (s_off |-> result_rdata_out == 8'h00)
    else $error("result visible while disabled");
  chk_rsvd_zero: assert property
    (ctl_rdata_out[14:13] == 2'h0)
    else $error("reserved bits set");
endmodule // adsc_control_props

bind adsc_control adsc_control_props adsc_control_props_inst (.*);

// ===== tb/adsc_conv_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// analogue converter model
// ----------------------------------------
module adsc_conv_model
(
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       sample_in,
  input  wire logic [1:0] channel_in,
  output logic      [7:0] data_out
);
  int         n_done;
  int         len;
  logic       smp_q;
  logic [7:0] last_q;
  // result names its input; toggling junk outside sampling
  assign data_out = sample_in ? {6'h28, channel_in} : ~last_q;
  // count finished conversions and last sampling length
  always_ff @(posedge core_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      n_done <= 0;
      len    <= 0;
      smp_q  <= 1'b0;
      last_q <= 8'h00;
    end
    else
    begin
      smp_q  <= sample_in;
      last_q <= data_out;
      if (sample_in)
        len <= smp_q ? len + 1 : 1;
      if (smp_q && !sample_in)
        n_done <= n_done + 1;
    end
  end
endmodule // adsc_conv_model
